// ### design/csit_pkg.sv
// Shared constants, types and helpers of the camera sensor input block
package csit_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int CSIT_DATA_W     = 20;
  localparam int CSIT_COMP_W     = 10;
  localparam int CSIT_FIFO_DEPTH = 16;
  localparam int CSIT_EMB8_W     = 8;

  // ----------------------------------------------------------------
  // Timing code words, left-justified on 10 bits
  // ----------------------------------------------------------------
  localparam logic [9:0] CSIT_CODE_ONES = 10'h3ff;
  localparam logic [9:0] CSIT_CODE_ZERO = 10'h000;
  localparam int CSIT_XY_ONE = 9;
  localparam int CSIT_XY_F   = 8;
  localparam int CSIT_XY_V   = 7;
  localparam int CSIT_XY_H   = 6;

  // ----------------------------------------------------------------
  // 16-bit RGB field layout
  // ----------------------------------------------------------------
  localparam int CSIT_R_LSB = 11;
  localparam int CSIT_R_W   = 5;
  localparam int CSIT_G_LSB = 5;
  localparam int CSIT_G_W   = 6;
  localparam int CSIT_B_LSB = 0;
  localparam int CSIT_B_W   = 5;

  typedef enum logic [1:0] {
    CSIT_MODE_EMB8  = 2'h0,
    CSIT_MODE_EMB20 = 2'h1,
    CSIT_MODE_GATED = 2'h3
  } csit_mode_t;

  typedef enum logic [0:0] {
    CSIT_LS_BLANK  = 1'h0,
    CSIT_LS_ACTIVE = 1'h1
  } csit_line_t;

  typedef struct packed {
    logic                   pixel_clock;
    logic                   frame_sync;
    logic                   line_sync;
    logic [CSIT_DATA_W-1:0] data;
  } csit_pins_t;

  typedef struct packed {
    logic                   frame_start;
    logic                   line_start;
    logic                   field;
    logic [CSIT_COMP_W-1:0] c2;
    logic [CSIT_COMP_W-1:0] c1;
    logic [CSIT_COMP_W-1:0] c0;
  } csit_pixel_t;

  // Widen a right-justified w-bit component, repeating its top bits below
  function automatic logic [9:0] csit_widen(input logic [9:0] raw, input int w);
    logic [9:0] r;
    r = raw << (CSIT_COMP_W - w);
    for (int i = 0; i < CSIT_COMP_W - w; i++)
      r[i] = r[9 - ((9 - i) % w)];
    return r;
  endfunction : csit_widen

endpackage : csit_pkg

// ### design/csit_fifo.sv
// Pixel FIFO with registered read data
module csit_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  // Fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // Drain side
  output logic                  o_valid,
  output logic [WIDTH-1:0]      o_data,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             wr;
  logic             rd;

  // Count excludes the output register, so full is exact
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign wr      = i_valid & o_ready;
  assign rd      = (count != '0) & (~o_valid | i_ready);

  // Storage has no reset; only written words are ever read
  always_ff @(posedge i_clock)
  begin
    if (wr)
      mem[wptr] <= i_data;
  end

  // Pointers and fill level
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      if (wr)
        wptr <= wptr + 1'b1;
      if (rd)
        rptr <= rptr + 1'b1;
      count <= count + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  // Output register
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_valid <= 1'b0;
      o_data  <= '0;
    end
    else if (rd)
    begin
      o_valid <= 1'b1;
      o_data  <= mem[rptr];
    end
    else if (i_ready)
      o_valid <= 1'b0;
  end

endmodule : csit_fifo

// ### design/csit_code_decoder.sv
// Embedded timing code finder that strips code words from the stream
module csit_code_decoder
  import csit_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  // Incoming beats
  input  wire logic                   i_valid,
  input  wire logic [CSIT_DATA_W-1:0] i_word,
  // Cleaned stream, three beats late
  output logic                        o_valid,
  output logic [CSIT_DATA_W-1:0]      o_word,
  // Decoded timing code
  output logic                        o_code,
  output logic                        o_field,
  output logic                        o_vblank,
  output logic                        o_hblank
);
  logic [2:0]             pv;
  logic [CSIT_DATA_W-1:0] pw0;
  logic [CSIT_DATA_W-1:0] pw1;
  logic [CSIT_DATA_W-1:0] pw2;
  logic                   hit;

  // Preamble ones, zero, zero then a word with its top bit set
  assign hit = i_valid & (&pv) & i_word[CSIT_DATA_W-1] &
               (pw2[CSIT_DATA_W-1 -: 10] == CSIT_CODE_ONES) &
               (pw1[CSIT_DATA_W-1 -: 10] == CSIT_CODE_ZERO) &
               (pw0[CSIT_DATA_W-1 -: 10] == CSIT_CODE_ZERO);

  // Three-beat delay line; a hit wipes the held preamble
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pv  <= '0;
      pw0 <= '0;
      pw1 <= '0;
      pw2 <= '0;
    end
    else if (hit)
      pv <= '0;
    else if (i_valid)
    begin
      pv  <= {pv[1:0], 1'b1};
      pw2 <= pw1;
      pw1 <= pw0;
      pw0 <= i_word;
    end
  end

  // Outputs, one cycle after the beat
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_valid  <= 1'b0;
      o_word   <= '0;
      o_code   <= 1'b0;
      o_field  <= 1'b0;
      o_vblank <= 1'b1;
      o_hblank <= 1'b1;
    end
    else
    begin
      o_valid <= i_valid & ~hit & pv[2];
      o_word  <= pw2;
      o_code  <= hit;
      if (hit)
      begin
        o_field  <= i_word[CSIT_DATA_W-10+CSIT_XY_F];
        o_vblank <= i_word[CSIT_DATA_W-10+CSIT_XY_V];
        o_hblank <= i_word[CSIT_DATA_W-10+CSIT_XY_H];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // A code cycle and the one after it never carry a data word
  property p_code_dropped;
    @(posedge i_clock) disable iff (!i_reset_n)
    o_code |-> !o_valid ##1 !o_valid;
  endproperty
  a_code_dropped: assert property (p_code_dropped)
    else $error("timing code word leaked into stream");

endmodule : csit_code_decoder

// ### design/csit_camera_input.sv
// Camera sensor input: pin sampling, timing modes, pixel packing and FIFO
//
// Notes on behaviour
// - Three timing modes exist: 8-bit embedded sync, 16/20-bit embedded sync, gated clock.
// - Timing code words are found, removed from the stream, and turned into frame and line syncs.
// - The 8-bit embedded mode takes one colour component per pixel clock.
// - The 16/20-bit embedded mode takes two colour components per pixel clock.
// - In gated mode a rising frame sync starts a new frame.
// - In gated mode pixel clock edges count only while line sync is high.
// - In gated mode data is sampled on each rising edge of a valid pixel clock.
// - In gated mode pixel clock edges are ignored once line sync drops, until it rises again.
// - A narrow component is widened by copying its top bits into the empty low bits.
// - 8-bit luma/chroma is taken only in the 8-bit embedded mode.
// - 16-bit RGB is taken either raw as generic data or unpacked into widened components.
// - 20-bit luma/chroma is taken only in the 16/20-bit embedded mode.
module csit_camera_input
  import csit_pkg::*;
#(
  parameter int FIFO_DEPTH = CSIT_FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  // Sensor pins
  input  wire logic                   i_cam_pixel_clock,
  input  wire logic                   i_cam_frame_sync,
  input  wire logic                   i_cam_line_sync,
  input  wire logic [CSIT_DATA_W-1:0] i_cam_data_bus,
  // Static configuration
  input  wire csit_mode_t             i_mode,
  input  wire logic                   i_frame_invert,
  input  wire logic                   i_line_invert,
  input  wire logic                   i_rgb_process,
  // Pixel stream out
  output logic                        o_pix_valid,
  output csit_pixel_t                 o_pix,
  input  wire logic                   i_pix_ready,
  // Status
  output logic                        o_frame_active,
  output logic                        o_line_active,
  output logic                        o_overflow
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  csit_pins_t             pin_raw;
  csit_pins_t             sync1;
  csit_pins_t             sync2;
  logic                   pclk_prev;
  logic                   frame_prev;
  logic                   line_prev;
  logic                   frame_lvl;
  logic                   line_lvl;
  logic                   pclk_rise;
  logic [2:0]             settle;
  logic                   gated;
  logic                   embedded;
  logic                   gated_beat;
  logic                   emb_beat;
  logic [CSIT_DATA_W-1:0] emb_word;
  logic                   dec_valid;
  logic [CSIT_DATA_W-1:0] dec_word;
  logic                   dec_code;
  logic                   dec_f;
  logic                   dec_v;
  logic                   dec_h;
  csit_line_t             line_state;
  csit_line_t             next_line_state;
  logic                   field;
  logic                   vblank;
  logic                   frame_set;
  logic                   line_set;
  logic                   frame_pend;
  logic                   line_pend;
  logic                   cand_valid;
  csit_pixel_t            next_pix;
  logic                   push_valid;
  csit_pixel_t            push_data;
  logic                   fifo_ready;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  assign pin_raw = {i_cam_pixel_clock, i_cam_frame_sync,
                    i_cam_line_sync, i_cam_data_bus};

  // Two stages keep every pin, data included, on one latency
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  // Previous levels for edge finding; settle masks edges while reset zeros, not pin levels, fill the stages,
  // since an inverted sync pin idling high would otherwise fake a rising edge just after reset
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pclk_prev  <= 1'b0;
      frame_prev <= 1'b0;
      line_prev  <= 1'b0;
      settle     <= '0;
    end
    else
    begin
      pclk_prev  <= sync2.pixel_clock;
      frame_prev <= frame_lvl;
      line_prev  <= line_lvl;
      settle     <= {settle[1:0], 1'b1};
    end
  end

  // Polarity, edges and mode decode
  assign frame_lvl  = sync2.frame_sync ^ i_frame_invert;
  assign line_lvl   = sync2.line_sync ^ i_line_invert;
  assign pclk_rise  = settle[2] & sync2.pixel_clock & ~pclk_prev;
  assign gated      = (i_mode == CSIT_MODE_GATED);
  assign embedded   = (i_mode == CSIT_MODE_EMB8) | (i_mode == CSIT_MODE_EMB20);
  // Sync pins are ignored in embedded modes; the sensor sends none
  assign gated_beat = gated & pclk_rise & line_lvl;
  assign emb_beat   = embedded & pclk_rise;

  // ----------------------------------------------------------------
  // Embedded timing codes
  // ----------------------------------------------------------------
  // 8-bit words are widened so one finder serves both widths
  assign emb_word = (i_mode == CSIT_MODE_EMB8) ?
    {csit_widen(10'(sync2.data[CSIT_EMB8_W-1:0]), CSIT_EMB8_W), CSIT_CODE_ZERO} :
    sync2.data;

  csit_code_decoder u_decoder (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_valid   (emb_beat),
    .i_word    (emb_word),
    .o_valid   (dec_valid),
    .o_word    (dec_word),
    .o_code    (dec_code),
    .o_field   (dec_f),
    .o_vblank  (dec_v),
    .o_hblank  (dec_h)
  );

  // Line opens on a start code outside vertical blanking
  always_comb
  begin
    next_line_state = line_state;
    if (!embedded)
      next_line_state = CSIT_LS_BLANK;
    else if (dec_code)
    begin
      unique case (line_state)
        CSIT_LS_BLANK:
          if (!dec_h && !dec_v)
            next_line_state = CSIT_LS_ACTIVE;
        CSIT_LS_ACTIVE:
          if (dec_h || dec_v)
            next_line_state = CSIT_LS_BLANK;
      endcase
    end
  end

  // Regenerated frame and field state
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      line_state <= CSIT_LS_BLANK;
      field      <= 1'b0;
      vblank     <= 1'b1;
    end
    else
    begin
      line_state <= next_line_state;
      if (dec_code)
      begin
        field  <= dec_f;
        vblank <= dec_v;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame and line start marks
  // ----------------------------------------------------------------
  // Embedded frame starts at the first active start code after blanking
  assign frame_set = gated ? (settle[2] & frame_lvl & ~frame_prev) :
                     (dec_code & ~dec_h & ~dec_v & vblank);
  assign line_set  = gated ? (settle[2] & line_lvl & ~line_prev) :
                     (dec_code & ~dec_h & ~dec_v);

  // A word formed in the same cycle carries the new mark, so none is lost
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      frame_pend <= 1'b0;
      line_pend  <= 1'b0;
    end
    else
    begin
      frame_pend <= ~cand_valid & (frame_pend | frame_set);
      line_pend  <= ~cand_valid & (line_pend | line_set);
    end
  end

  // ----------------------------------------------------------------
  // Pixel packing
  // ----------------------------------------------------------------
  assign cand_valid = gated_beat |
                      (embedded & dec_valid & (line_state == CSIT_LS_ACTIVE));

  always_comb
  begin
    next_pix = '0;
    if (gated)
    begin
      if (i_rgb_process)
      begin
        // Unpacked RGB, each field widened to full width
        next_pix.c0 = csit_widen(10'(sync2.data[CSIT_R_LSB +: CSIT_R_W]), CSIT_R_W);
        next_pix.c1 = csit_widen(10'(sync2.data[CSIT_G_LSB +: CSIT_G_W]), CSIT_G_W);
        next_pix.c2 = csit_widen(10'(sync2.data[CSIT_B_LSB +: CSIT_B_W]), CSIT_B_W);
      end
      else
      begin
        // Generic data passes untouched
        next_pix.c0 = sync2.data[CSIT_DATA_W-1 -: CSIT_COMP_W];
        next_pix.c1 = sync2.data[CSIT_COMP_W-1:0];
      end
    end
    else
    begin
      next_pix.c0    = dec_word[CSIT_DATA_W-1 -: CSIT_COMP_W];
      next_pix.field = field;
      if (i_mode == CSIT_MODE_EMB20)
        next_pix.c1 = dec_word[CSIT_COMP_W-1:0];
    end
    next_pix.frame_start = frame_pend | frame_set;
    next_pix.line_start  = line_pend | line_set;
  end

  // Push register in front of the FIFO
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      push_valid <= 1'b0;
      push_data  <= '0;
    end
    else
    begin
      push_valid <= cand_valid;
      if (cand_valid)
        push_data <= next_pix;
    end
  end

  // The sensor cannot be stalled; a full FIFO drops the word and says so
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_overflow <= 1'b0;
    else if (push_valid && !fifo_ready)
      o_overflow <= 1'b1;
    else if (frame_set)
      o_overflow <= 1'b0;
  end

  // Status levels
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_frame_active <= 1'b0;
      o_line_active  <= 1'b0;
    end
    else
    begin
      o_frame_active <= embedded ? ~vblank : (gated & frame_lvl);
      o_line_active  <= embedded ? (line_state == CSIT_LS_ACTIVE) : (gated & line_lvl);
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------
  csit_fifo #(
    .WIDTH ($bits(csit_pixel_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_valid   (push_valid),
    .i_data    (push_data),
    .o_ready   (fifo_ready),
    .o_valid   (o_pix_valid),
    .o_data    (o_pix),
    .i_ready   (i_pix_ready)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_one_mode;
    !(gated_beat && emb_beat);
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("gated and embedded beats at once");
  property p_sav_opens_line;
    embedded && dec_code && !dec_h && !dec_v |=> line_state == CSIT_LS_ACTIVE && next_pix.line_start;
  endproperty
  a_sav_opens_line: assert property (p_sav_opens_line)
    else $error("start code did not open a line");
  property p_one_comp;
    i_mode == CSIT_MODE_EMB8 && cand_valid |=> push_valid && push_data.c1 == '0 && push_data.c2 == '0;
  endproperty
  a_one_comp: assert property (p_one_comp)
    else $error("8-bit mode packed more than one component");
  property p_two_comp;
    i_mode == CSIT_MODE_EMB20 && cand_valid |=> push_data.c1 == $past(dec_word[CSIT_COMP_W-1:0]);
  endproperty
  a_two_comp: assert property (p_two_comp)
    else $error("second component lost in 16/20-bit mode");
  property p_frame_mark;
    gated && settle[2] && frame_lvl && !frame_prev && !cand_valid |=> frame_pend;
  endproperty
  a_frame_mark: assert property (p_frame_mark)
    else $error("frame sync rise not marked");
  property p_line_gate;
    gated && !line_lvl |=> !push_valid;
  endproperty
  a_line_gate: assert property (p_line_gate)
    else $error("pixel taken while line sync low");
  property p_gated_sample;
    gated_beat && !i_rgb_process |=> push_valid && push_data.c0 == $past(sync2.data[CSIT_DATA_W-1 -: CSIT_COMP_W]);
  endproperty
  a_gated_sample: assert property (p_gated_sample)
    else $error("gated beat not sampled");
  property p_widen8;
    i_mode == CSIT_MODE_EMB8 && push_valid |-> push_data.c0[1:0] == push_data.c0[9:8];
  endproperty
  a_widen8: assert property (p_widen8)
    else $error("8-bit component not widened");

  // Main scenarios
  c_gated_frame: cover property (gated && frame_set ##[1:200] push_valid && push_data.frame_start);
  c_emb_code:    cover property (embedded && dec_code && !dec_h ##[1:100] push_valid);
  c_overflow:    cover property (push_valid && !fifo_ready);

endmodule : csit_camera_input

// ### bench/csit_sensor.sv
// Behavioural image sensor driving the camera pins
module csit_sensor
  import csit_pkg::*;
(
  // Sensor pins
  output logic                   o_pixel_clock,
  output logic                   o_frame_sync,
  output logic                   o_line_sync,
  output logic [CSIT_DATA_W-1:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------
  // Pin drivers
  // ------------------------------
  // Pixel clock stands low between beats
  initial
  begin
    o_pixel_clock = 1'b0;
    o_frame_sync  = 1'b0;
    o_line_sync   = 1'b0;
    o_data        = '0;
  end

  // One beat; 20 ns after the rise the bus shows the inverse, never a stale word,
  // and the bus is never assigned twice in one step between back-to-back beats
  task automatic beat(input logic [CSIT_DATA_W-1:0] word);
    o_data = word;
    #40;
    o_pixel_clock = 1'b1;
    #20;
    o_data = ~word;
    #20;
    o_pixel_clock = 1'b0;
  endtask : beat

  // Sync pin levels, held one pixel period
  task automatic syncs(input logic fs, input logic ls);
    o_frame_sync = fs;
    o_line_sync  = ls;
    #80;
  endtask : syncs

  // Timing code on the top ten bits, or on the low byte for the narrow mode
  task automatic code(input logic n8, input logic f, input logic v, input logic h);
    logic [9:0] xy;
    logic [9:0] w [4];
    xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
    w = '{10'h3ff, 10'h000, 10'h000, xy};
    foreach (w[i])
      beat(n8 ? {12'h000, w[i][9:2]} : {w[i], 10'h000});
    #80;
  endtask : code
endmodule : csit_sensor

// ### bench/csit_camera_input_tb.sv
// Self-checking bench of the camera sensor input block
module csit_camera_input_tb
  import csit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------
  // Signals and ordinary cases
  // ------------------------------
  typedef struct packed {
    logic        rgb;
    logic [19:0] d;
    logic [9:0]  c0;
    logic [9:0]  c1;
    logic [9:0]  c2;
  } csit_row_t;
  localparam csit_row_t ROWS [4] = '{
    '{1'b0, 20'habcde, 10'h2af, 10'h0de, 10'h000},
    '{1'b0, 20'h00001, 10'h000, 10'h001, 10'h000},
    '{1'b1, 20'h08410, 10'h210, 10'h208, 10'h210},
    '{1'b1, 20'h007e0, 10'h000, 10'h3ff, 10'h000}};
  localparam logic [19:0] EMB [3] = '{20'h12345, 20'h2a5c3, 20'h3c00f};
  logic                   clock, reset_n, pclk, fs, ls, invf, invl, rgb, ready;
  logic                   pix_valid, frame_act, line_act, ovf;
  logic [CSIT_DATA_W-1:0] data;
  csit_mode_t             mode;
  csit_pixel_t            pix;
  csit_pixel_t            got [$];
  int                     num_errors, compares;

  csit_sensor u_csit_sensor (.o_pixel_clock(pclk), .o_frame_sync(fs), .o_line_sync(ls), .o_data(data));

  csit_camera_input u_csit_camera_input (
    .i_clock(clock), .i_reset_n(reset_n), .i_cam_pixel_clock(pclk), .i_cam_frame_sync(fs),
    .i_cam_line_sync(ls), .i_cam_data_bus(data), .i_mode(mode), .i_frame_invert(invf),
    .i_line_invert(invl), .i_rgb_process(rgb), .o_pix_valid(pix_valid), .o_pix(pix),
    .i_pix_ready(ready), .o_frame_active(frame_act), .o_line_active(line_act), .o_overflow(ovf));

  // 100 MHz system clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Collect each word the consumer takes; pre-edge values give the handshake
  always @(posedge clock)
    if (pix_valid === 1'b1 && ready === 1'b1)
      got.push_back(pix);

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic check_comp(input logic [9:0] act, input logic [9:0] exp);
    compares++;
    if (act !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : check_comp

  task automatic check_flag(input logic act, input logic exp);
    check_comp({9'h000, act}, {9'h000, exp});
  endtask : check_flag

  // Bounded wait for the next word; an empty queue yields unknowns
  task automatic take(output csit_pixel_t w);
    for (int n = 0; n < 50 && got.size() == 0; n++)
      @(negedge clock);
    w = (got.size() != 0) ? got.pop_front() : 'x;
  endtask : take

  // Reset for twelve cycles; mode is only changed while held here
  task automatic start();
    reset_n = 1'b0;
    repeat (12) @(negedge clock);
    check_flag(pix_valid, 1'b0);
    check_flag(ovf, 1'b0);
    reset_n = 1'b1;
    repeat (2) @(negedge clock);
    got.delete();
  endtask : start

  task automatic complete_run();
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ------------------------------
  // Test sequence
  // ------------------------------
  // Rows first, then line ends, polarity, overflow, illegal and embedded modes
  initial
  begin
    csit_pixel_t w;
    {num_errors, compares, reset_n, invf, invl, rgb} = '0;
    ready = 1'b1;
    mode = CSIT_MODE_GATED;
    @(negedge clock);
    start();
    foreach (ROWS[i])
    begin
      rgb = ROWS[i].rgb;
      u_csit_sensor.syncs(1'b0, 1'b0);
      u_csit_sensor.syncs(1'b1, 1'b1);
      u_csit_sensor.beat(ROWS[i].d);
      u_csit_sensor.syncs(1'b1, 1'b0);
      take(w);
      check_flag(w.frame_start, 1'b1);
      check_flag(w.line_start, 1'b1);
      check_comp(w.c0, ROWS[i].c0);
      check_comp(w.c1, ROWS[i].c1);
      if (ROWS[i].rgb)
        check_comp(w.c2, ROWS[i].c2);
    end
    rgb = 1'b0;
    u_csit_sensor.syncs(1'b1, 1'b1);
    check_flag(frame_act, 1'b1);
    check_flag(line_act, 1'b1);
    for (int k = 1; k < 4; k++)
      u_csit_sensor.beat(20'(k));
    u_csit_sensor.syncs(1'b1, 1'b0);
    u_csit_sensor.beat(20'h00077);
    u_csit_sensor.syncs(1'b1, 1'b0);
    check_comp(10'(got.size()), 10'h003);
    take(w);
    take(w);
    check_flag(w.line_start, 1'b0);
    check_comp(w.c1, 10'h002);
    take(w);
    u_csit_sensor.syncs(1'b1, 1'b1);
    invl = 1'b1;
    u_csit_sensor.syncs(1'b1, 1'b0);
    u_csit_sensor.beat(20'h00055);
    u_csit_sensor.syncs(1'b1, 1'b1);
    take(w);
    check_comp(w.c1, 10'h055);
    {invl, invf, ready} = 3'b010;
    u_csit_sensor.syncs(1'b1, 1'b0);
    u_csit_sensor.syncs(1'b0, 1'b1);
    check_flag(frame_act, 1'b1);
    for (int k = 0; k < 20; k++)
      u_csit_sensor.beat(20'(k));
    u_csit_sensor.syncs(1'b0, 1'b0);
    check_flag(ovf, 1'b1);
    ready = 1'b1;
    take(w);
    check_flag(w.frame_start, 1'b1);
    check_comp(w.c1, 10'h000);
    repeat (40) @(negedge clock);
    mode = csit_mode_t'(2'h2);
    start();
    u_csit_sensor.syncs(1'b1, 1'b1);
    u_csit_sensor.beat(20'h00011);
    u_csit_sensor.syncs(1'b1, 1'b0);
    check_comp(10'(got.size()), 10'h000);
    mode = CSIT_MODE_EMB20;
    start();
    u_csit_sensor.code(1'b0, 1'b0, 1'b0, 1'b0);
    check_flag(frame_act, 1'b1);
    check_flag(line_act, 1'b1);
    u_csit_sensor.beat(EMB[0]);
    u_csit_sensor.beat(EMB[1]);
    u_csit_sensor.code(1'b0, 1'b0, 1'b0, 1'b1);
    check_flag(line_act, 1'b0);
    u_csit_sensor.beat(20'h00200);
    u_csit_sensor.code(1'b0, 1'b1, 1'b0, 1'b0);
    u_csit_sensor.beat(EMB[2]);
    u_csit_sensor.code(1'b0, 1'b1, 1'b0, 1'b1);
    check_comp(10'(got.size()), 10'h003);
    foreach (EMB[i])
    begin
      take(w);
      check_comp(w.c0, EMB[i][19:10]);
      check_comp(w.c1, EMB[i][9:0]);
      check_flag(w.line_start, i != 1);
      check_flag(w.frame_start, i == 0);
      check_flag(w.field, i == 2);
    end
    mode = CSIT_MODE_EMB8;
    start();
    u_csit_sensor.code(1'b1, 1'b0, 1'b0, 1'b0);
    u_csit_sensor.beat(20'h000c5);
    u_csit_sensor.beat(20'h00040);
    u_csit_sensor.code(1'b1, 1'b0, 1'b0, 1'b1);
    take(w);
    check_comp(w.c0, 10'h317);
    take(w);
    check_comp(w.c0, 10'h101);
    complete_run();
  end

  // Watchdog, far beyond the expected run of some eight microseconds
  initial
  begin
    #300000;
    num_errors++;
    complete_run();
  end
endmodule : csit_camera_input_tb
